// File: malt_mgmt_model.sv
// management-side model that issues static address adds
`timescale 1ns/100ps
module malt_mgmt_model (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // request from the bench
  input  wire logic        req_i,
  input  wire logic [47:0] mac_i,
  input  wire logic [11:0] vid_i,
  input  wire logic        trunk_i,
  input  wire logic [4:0]  if_i,
  // static add towards the table
  output logic             st_add_o,
  output logic [47:0]      st_mac_o,
  output logic [11:0]      st_vid_o,
  output logic             st_trunk_o,
  output logic [4:0]       st_if_o
);
  // fields travel with the pulse; idle lines toggle so stale data is never trusted
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      st_add_o <= 1'b0;
      {st_mac_o, st_vid_o, st_trunk_o, st_if_o} <= '0;
    end
    else
    begin
      st_add_o <= req_i;
      if (req_i)
        {st_mac_o, st_vid_o, st_trunk_o, st_if_o} <= {mac_i, vid_i, trunk_i, if_i};
      else
        {st_mac_o, st_vid_o, st_trunk_o, st_if_o} <= ~{st_mac_o, st_vid_o, st_trunk_o, st_if_o};
    end
  end
endmodule : malt_mgmt_model

// File: malt_pkg.sv
// package of constants for the mac address learning table
package malt_pkg;
  localparam int          ENTRIES      = 16;
  localparam int          IDX_W        = 4;
  localparam int          CNT_W        = 5;
  localparam int          MAC_W        = 48;
  localparam int          VID_W        = 12;
  localparam int          IF_W         = 5;
  localparam int          PORTS        = 24;
  localparam int          AGE_W        = 17;
  localparam logic [11:0] VID_MIN      = 12'h001;
  localparam logic [11:0] VID_MAX      = 12'hFFE;
  localparam logic [16:0] AGE_MIN_S    = 17'h0000A;
  localparam logic [16:0] AGE_MAX_S    = 17'h17FFD;
  localparam logic [16:0] AGE_DEF_S    = 17'h0012C;
  localparam int          CLK_HZ       = 25000000;
  localparam int          TICK_W       = 25;
  localparam logic [24:0] TICK_CYCLES  = 25'(CLK_HZ);
  localparam logic [23:0] PORT_ALL     = 24'hFFFFFF;
endpackage : malt_pkg

// File: malt_sec_tick.sv
// one-second tick generator
`timescale 1ns/100ps
module malt_sec_tick #(
  parameter logic [24:0] CYCLES = malt_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rstn_i,
  // tick out
  output logic      tick_o
);
  logic [24:0] cnt_r;

  // free counter, pulse on wrap
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cnt_r  <= 25'h0000000;
      tick_o <= 1'b0;
    end
    else if (cnt_r >= CYCLES - 25'h0000001)
    begin
      cnt_r  <= 25'h0000000;
      tick_o <= 1'b1;
    end
    else
    begin
      cnt_r  <= cnt_r + 25'h0000001;
      tick_o <= 1'b0;
    end
  end
endmodule : malt_sec_tick

// File: malt_table.sv
// mac address learning table: learn, lookup, static add, aging
`timescale 1ns/100ps
// Function
// - static entries stay bound to their configured interface forever.
// - source seen on other interface for static entry: no table write.
// - learn source mac with vlan and ingress interface per frame.
// - destination hit on a port entry forwards only to that port; trunk hit gives empty mask.
// - destination miss floods to all ports.
// - each entry holds 48-bit mac and vlan 1 to 4094.
// - interface is port or trunk; trunk result marked as trunk.
// - dynamic entry discarded after aging time unrefreshed.
// - aging time 10 to 98301 s, default 300, separate enable.
// - readable counts of dynamic and static entries.
module malt_table #(
  parameter logic [24:0] TICK_CYCLES = malt_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // ingress frame (same clock domain)
  input  wire logic        frm_vld_i,
  input  wire logic [47:0] frm_sa_i,
  input  wire logic [47:0] frm_da_i,
  input  wire logic [11:0] frm_vid_i,
  input  wire logic        frm_trunk_i,
  input  wire logic [4:0]  frm_if_i,
  // forwarding decision
  output logic             fwd_vld_o,
  output logic             fwd_hit_o,
  output logic             fwd_trunk_o,
  output logic [4:0]       fwd_if_o,
  output logic [23:0]      fwd_mask_o,
  // management static add
  input  wire logic        st_add_i,
  input  wire logic [47:0] st_mac_i,
  input  wire logic [11:0] st_vid_i,
  input  wire logic        st_trunk_i,
  input  wire logic [4:0]  st_if_i,
  // aging control
  input  wire logic        age_en_i,
  input  wire logic [16:0] age_time_i,
  input  wire logic        age_time_wr_i,
  output logic [16:0]      age_time_o,
  // counts
  output logic [4:0]       dyn_cnt_o,
  output logic [4:0]       st_cnt_o
);
  // entry storage
  logic [47:0] mac_r   [malt_pkg::ENTRIES];
  logic [11:0] vid_r   [malt_pkg::ENTRIES];
  logic [4:0]  if_r    [malt_pkg::ENTRIES];
  logic [16:0] age_r   [malt_pkg::ENTRIES];
  logic [malt_pkg::ENTRIES-1:0] vld_r;
  logic [malt_pkg::ENTRIES-1:0] stat_r;
  logic [malt_pkg::ENTRIES-1:0] trk_r;
  logic        tick;
  logic        vid_ok;
  logic        sa_hit;
  logic [3:0]  sa_idx;
  logic        da_hit;
  logic [3:0]  da_idx;
  logic        st_hit;
  logic [3:0]  st_idx;
  logic        fr_free;
  logic [3:0]  fr_idx;
  logic        learn_wr;
  logic [3:0]  learn_idx;
  logic        st_wr;
  logic [3:0]  st_widx;
  logic [4:0]  dyn_cnt_nxt;
  logic [4:0]  st_cnt_nxt;

  // key compare, used for source, destination and static key
  function automatic logic key_eq(input logic v, input logic [47:0] a, input logic [47:0] b,
                                  input logic [11:0] va, input logic [11:0] vb);
    key_eq = v && (a == b) && (va == vb);
  endfunction : key_eq

  // vlan range check for both paths
  function automatic logic vid_valid(input logic [11:0] v);
    vid_valid = (v >= malt_pkg::VID_MIN) && (v <= malt_pkg::VID_MAX);
  endfunction : vid_valid

  malt_sec_tick #(
    .CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .tick_o (tick)
  );

  assign vid_ok = vid_valid(frm_vid_i);

  // parallel search; lowest index wins
  always_comb
  begin
    sa_hit  = 1'b0;
    sa_idx  = 4'h0;
    da_hit  = 1'b0;
    da_idx  = 4'h0;
    st_hit  = 1'b0;
    st_idx  = 4'h0;
    fr_free = 1'b0;
    fr_idx  = 4'h0;
    for (int i = malt_pkg::ENTRIES - 1; i >= 0; i--)
    begin
      if (key_eq(vld_r[i], mac_r[i], frm_sa_i, vid_r[i], frm_vid_i))
      begin
        sa_hit = 1'b1;
        sa_idx = 4'(i);
      end
      if (key_eq(vld_r[i], mac_r[i], frm_da_i, vid_r[i], frm_vid_i))
      begin
        da_hit = 1'b1;
        da_idx = 4'(i);
      end
      if (key_eq(vld_r[i], mac_r[i], st_mac_i, vid_r[i], st_vid_i))
      begin
        st_hit = 1'b1;
        st_idx = 4'(i);
      end
      if (!vld_r[i])
      begin
        fr_free = 1'b1;
        fr_idx  = 4'(i);
      end
    end
  end

  // static add has priority over learning in the same cycle
  assign st_wr    = st_add_i && vid_valid(st_vid_i) && (st_hit || fr_free);
  assign st_widx  = st_hit ? st_idx : fr_idx;
  // a static hit is never rewritten by learning; full table drops new sources
  assign learn_wr = frm_vld_i && vid_ok && !st_wr &&
                    (sa_hit ? !stat_r[sa_idx] : fr_free);
  assign learn_idx = sa_hit ? sa_idx : fr_idx;

  // entry contents
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      vld_r  <= '0;
      stat_r <= '0;
      trk_r  <= '0;
      for (int i = 0; i < malt_pkg::ENTRIES; i++)
      begin
        mac_r[i] <= 48'h000000000000;
        vid_r[i] <= 12'h000;
        if_r[i]  <= 5'h00;
        age_r[i] <= 17'h00000;
      end
    end
    else
    begin
      // aging: count seconds, drop expired dynamic entries only
      for (int i = 0; i < malt_pkg::ENTRIES; i++)
      begin
        if (vld_r[i] && !stat_r[i] && age_en_i && tick)
        begin
          if (age_r[i] + 17'h00001 >= age_time_o)
            vld_r[i] <= 1'b0;
          else
            age_r[i] <= age_r[i] + 17'h00001;
        end
      end
      if (learn_wr)
      begin
        vld_r[learn_idx]  <= 1'b1;
        stat_r[learn_idx] <= 1'b0;
        trk_r[learn_idx]  <= frm_trunk_i;
        mac_r[learn_idx]  <= frm_sa_i;
        vid_r[learn_idx]  <= frm_vid_i;
        if_r[learn_idx]   <= frm_if_i;
        age_r[learn_idx]  <= 17'h00000; // refresh
      end
      if (st_wr)
      begin
        vld_r[st_widx]  <= 1'b1;
        stat_r[st_widx] <= 1'b1;
        trk_r[st_widx]  <= st_trunk_i;
        mac_r[st_widx]  <= st_mac_i;
        vid_r[st_widx]  <= st_vid_i;
        if_r[st_widx]   <= st_if_i;
        age_r[st_widx]  <= 17'h00000;
      end
    end
  end

  // aging time register, out-of-range writes ignored
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      age_time_o <= malt_pkg::AGE_DEF_S;
    else if (age_time_wr_i && age_time_i >= malt_pkg::AGE_MIN_S && age_time_i <= malt_pkg::AGE_MAX_S)
      age_time_o <= age_time_i;
  end

  // forwarding decision, one cycle after the frame
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      fwd_vld_o   <= 1'b0;
      fwd_hit_o   <= 1'b0;
      fwd_trunk_o <= 1'b0;
      fwd_if_o    <= 5'h00;
      fwd_mask_o  <= 24'h000000;
    end
    else
    begin
      fwd_vld_o   <= frm_vld_i;
      fwd_hit_o   <= frm_vld_i && vid_ok && da_hit;
      fwd_trunk_o <= frm_vld_i && vid_ok && da_hit && trk_r[da_idx];
      fwd_if_o    <= da_hit ? if_r[da_idx] : 5'h00;
      if (vid_ok && da_hit && !trk_r[da_idx])
        fwd_mask_o <= 24'h000001 << if_r[da_idx];
      else if (vid_ok && da_hit)
        fwd_mask_o <= 24'h000000; // trunk: member choice is downstream
      else
        fwd_mask_o <= malt_pkg::PORT_ALL;
    end
  end

  // entry counts from the valid and static flags
  always_comb
  begin
    dyn_cnt_nxt = 5'h00;
    st_cnt_nxt  = 5'h00;
    for (int i = 0; i < malt_pkg::ENTRIES; i++)
    begin
      dyn_cnt_nxt = dyn_cnt_nxt + 5'(vld_r[i] && !stat_r[i]);
      st_cnt_nxt  = st_cnt_nxt + 5'(vld_r[i] && stat_r[i]);
    end
  end

  // counts registered so readers see flop outputs; they lag the table by one cycle
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      dyn_cnt_o <= 5'h00;
      st_cnt_o  <= 5'h00;
    end
    else
    begin
      dyn_cnt_o <= dyn_cnt_nxt;
      st_cnt_o  <= st_cnt_nxt;
    end
  end

  // assertions
  a_fwd_flood: assert property (@(posedge clk_i) disable iff (!rstn_i)
    frm_vld_i && !da_hit |=> fwd_mask_o == malt_pkg::PORT_ALL && !fwd_hit_o)
    else $error("miss did not flood");
  a_fwd_single: assert property (@(posedge clk_i) disable iff (!rstn_i)
    fwd_vld_o && fwd_hit_o && !fwd_trunk_o |-> $onehot(fwd_mask_o))
    else $error("hit not forwarded to one port");
  a_static_kept: assert property (@(posedge clk_i) disable iff (!rstn_i)
    frm_vld_i && sa_hit && stat_r[sa_idx] && !st_add_i |=> if_r[$past(sa_idx)] == $past(if_r[sa_idx]))
    else $error("static entry moved");
  a_learn_write: assert property (@(posedge clk_i) disable iff (!rstn_i)
    learn_wr |=> vld_r[$past(learn_idx)] && mac_r[$past(learn_idx)] == $past(frm_sa_i))
    else $error("source not learned");
  a_static_never_aged: assert property (@(posedge clk_i) disable iff (!rstn_i)
    st_cnt_nxt > 5'h00 && !st_add_i |=> st_cnt_nxt >= $past(st_cnt_nxt))
    else $error("static entry lost");
  a_age_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !age_en_i && !st_wr |=> dyn_cnt_nxt >= $past(dyn_cnt_nxt))
    else $error("dynamic entry lost with aging off");
  a_age_range: assert property (@(posedge clk_i) disable iff (!rstn_i)
    age_time_o >= malt_pkg::AGE_MIN_S && age_time_o <= malt_pkg::AGE_MAX_S)
    else $error("aging time out of range");
  a_vid_range: assert property (@(posedge clk_i) disable iff (!rstn_i)
    frm_vld_i && !vid_ok |=> !fwd_hit_o)
    else $error("bad vlan hit");
endmodule : malt_table

// File: malt_table_tb.sv
// self-checking bench for the address table
`timescale 1ns/100ps
module malt_table_tb;
  logic        clk_i = 1'b0, rstn_i = 1'b0, frm_vld_i = 1'b0, frm_trunk_i = 1'b0;
  logic        age_en_i = 1'b0, age_time_wr_i = 1'b0, req = 1'b0, fwd_vld_o, fwd_hit_o, fwd_trunk_o;
  logic [47:0] frm_sa_i = '0, frm_da_i = '0, ma, mb, mc, mx;
  logic [11:0] frm_vid_i = '0;
  logic [4:0]  frm_if_i = '0, fwd_if_o, dyn_cnt_o, st_cnt_o;
  logic [16:0] age_time_i = '0, age_time_o;
  logic [23:0] fwd_mask_o;
  logic        st_add_i, st_trunk_i;
  logic [47:0] st_mac_i;
  logic [11:0] st_vid_i;
  logic [4:0]  st_if_i;
  logic [47:0] smac = '0;
  logic [11:0] svid = '0;
  logic        strk = 1'b0;
  logic [4:0]  sif = '0;
  logic [30:0] q[$];
  logic [30:0] e;
  int          n_errors = 0, comparisons = 0, cyc = 0;

  malt_table #(.TICK_CYCLES(25'h000000A)) DUT (.clk_i(clk_i), .rstn_i(rstn_i), .frm_vld_i(frm_vld_i),
    .frm_sa_i(frm_sa_i), .frm_da_i(frm_da_i), .frm_vid_i(frm_vid_i), .frm_trunk_i(frm_trunk_i),
    .frm_if_i(frm_if_i), .fwd_vld_o(fwd_vld_o), .fwd_hit_o(fwd_hit_o), .fwd_trunk_o(fwd_trunk_o),
    .fwd_if_o(fwd_if_o), .fwd_mask_o(fwd_mask_o), .st_add_i(st_add_i), .st_mac_i(st_mac_i),
    .st_vid_i(st_vid_i), .st_trunk_i(st_trunk_i), .st_if_i(st_if_i), .age_en_i(age_en_i),
    .age_time_i(age_time_i), .age_time_wr_i(age_time_wr_i), .age_time_o(age_time_o),
    .dyn_cnt_o(dyn_cnt_o), .st_cnt_o(st_cnt_o));
  malt_mgmt_model u_mgmt (.clk_i(clk_i), .rstn_i(rstn_i), .req_i(req), .mac_i(smac), .vid_i(svid),
    .trunk_i(strk), .if_i(sif), .st_add_o(st_add_i), .st_mac_o(st_mac_i), .st_vid_o(st_vid_i),
    .st_trunk_o(st_trunk_i), .st_if_o(st_if_i));

  // 25 mhz clock
  always #20 clk_i = ~clk_i;

  task chk(input logic [24:0] got, input logic [24:0] exp, input string m);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : chk

  // one frame; the expected decision is noted before it is sent
  task frm(input logic [47:0] sa, input logic [47:0] da, input logic [11:0] v, input logic t,
           input logic [4:0] f, input logic [30:0] x);
    q.push_back(x);
    {frm_sa_i, frm_da_i, frm_vid_i, frm_trunk_i, frm_if_i} <= {sa, da, v, t, f};
    frm_vld_i <= 1'b1;
    @(posedge clk_i);
    frm_vld_i <= 1'b0;
    @(posedge clk_i);
  endtask : frm

  // one static add through the management model; waits until the counts settle
  task mgmt_add(input logic [47:0] m, input logic [11:0] v, input logic t, input logic [4:0] f);
    {smac, svid, strk, sif} <= {m, v, t, f};
    req <= 1'b1;
    @(posedge clk_i);
    req <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask : mgmt_add

  task close_out;
    // a decision that never came is a mismatch too
    if (q.size() != 0)
    begin
      n_errors++;
      $display("wrong value at %0t: forward decision missing", $time);
    end
    $display("checks %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out

  // decision monitor: oldest note against each forwarding result
  always @(posedge clk_i)
  begin
    if (fwd_vld_o === 1'b1)
    begin
      e = (q.size() > 0) ? q.pop_front() : 31'h7FFFFFFF;
      comparisons++;
      if ({fwd_hit_o, fwd_trunk_o, fwd_if_o, fwd_mask_o} !== e)
      begin
        n_errors++;
        $display("wrong value at %0t: forward decision", $time);
      end
    end
  end

  // hang guard, well above the few hundred cycles the run needs
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_errors++;
      close_out();
    end
  end

  logic [16:0] av[4] = '{17'h00009, 17'h17FFE, 17'h17FFD, 17'h0000A};
  logic [16:0] ae[4] = '{17'h0012C, 17'h0012C, 17'h17FFD, 17'h0000A};

  initial
  begin
    void'($urandom(81));
    ma = {16'h0A00, 32'($urandom)};
    mb = {16'h0B00, 32'($urandom)};
    mc = {16'h0C00, 32'($urandom)};
    mx = {16'h0D00, 32'($urandom)};
    repeat (6) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    chk(25'(age_time_o), 25'h000012C, "aging default");
    chk(25'({dyn_cnt_o, st_cnt_o}), 25'h0, "counts after reset");
    frm(ma, mx, 12'h001, 1'b0, 5'h03, {2'b00, 5'h00, 24'hFFFFFF});
    frm(mx, ma, 12'h001, 1'b0, 5'h04, {2'b10, 5'h03, 24'h000008});
    frm(mc, ma, 12'h000, 1'b0, 5'h06, {2'b00, 5'h00, 24'hFFFFFF});
    frm(mc, ma, 12'hFFF, 1'b0, 5'h06, {2'b00, 5'h00, 24'hFFFFFF});
    chk(25'(dyn_cnt_o), 25'h2, "learned count");
    frm(mc, mx, 12'h001, 1'b1, 5'h02, {2'b10, 5'h04, 24'h000010});
    frm(mx, mc, 12'h001, 1'b0, 5'h04, {2'b11, 5'h02, 24'h000000});
    $display("test learn done");
    mgmt_add(mb, 12'h001, 1'b0, 5'h05);
    chk(25'({dyn_cnt_o, st_cnt_o}), 25'h61, "static count");
    mgmt_add(mc, 12'h001, 1'b1, 5'h09);
    mgmt_add(mx, 12'h000, 1'b0, 5'h07);
    chk(25'({dyn_cnt_o, st_cnt_o}), 25'h42, "static convert, bad vlan refused");
    frm(mb, ma, 12'h001, 1'b0, 5'h07, {2'b10, 5'h03, 24'h000008});
    frm(ma, mb, 12'h001, 1'b0, 5'h03, {2'b10, 5'h05, 24'h000020});
    frm(ma, mc, 12'h001, 1'b0, 5'h03, {2'b11, 5'h09, 24'h000000});
    chk(25'({dyn_cnt_o, st_cnt_o}), 25'h42, "no move");
    $display("test static done");
    for (int i = 0; i < 4; i++)
    begin
      age_time_i <= av[i];
      age_time_wr_i <= 1'b1;
      @(posedge clk_i);
      age_time_wr_i <= 1'b0;
      @(posedge clk_i);
      chk(25'(age_time_o), 25'(ae[i]), "aging time");
    end
    repeat (150) @(posedge clk_i);
    chk(25'(dyn_cnt_o), 25'h2, "kept while disabled");
    age_en_i <= 1'b1;
    repeat (150) @(posedge clk_i);
    chk(25'({dyn_cnt_o, st_cnt_o}), 25'h02, "aged out");
    frm(mx, ma, 12'h001, 1'b0, 5'h04, {2'b00, 5'h00, 24'hFFFFFF});
    frm(mx, mb, 12'h001, 1'b0, 5'h04, {2'b10, 5'h05, 24'h000020});
    $display("test aging done");
    // fill the table: two of these sources find no free entry and are dropped
    for (int i = 0; i < 15; i++)
      frm({16'h0E00, 28'($urandom), 4'(i)}, mb, 12'h001, 1'b0, 5'h01, {2'b10, 5'h05, 24'h000020});
    chk(25'({dyn_cnt_o, st_cnt_o}), 25'h1C2, "full table");
    $display("test full table done");
    // let the monitor take the last decision before the verdict
    @(posedge clk_i);
    close_out();
  end
endmodule : malt_table_tb
